// [hfc_header_field.sv]
// Header-field configuration and receive-status registers behind an APB slave.
// Assumes the receive parser and the controller's enable run on i_sys_clk.
//
// Functional notes
// [RULE1] Keep 2 Mbps code, send when selected
// [RULE2] Keep 5.5 Mbps code, send when selected
// [RULE3] Keep 11 Mbps code, send when selected
// [RULE4] Compare received signal byte with stored codes
// [RULE5] Rate bits 1:0 select transmitted code
// [RULE6] Controller sets rate 2us before use
// [RULE7] Rate bits 7:2 stored, otherwise unused
// [RULE8] Insert programmed service value in header
// [RULE9] Controller should program service as zero
// [RULE10] Length from high and low bytes
// [RULE11] Status 7:6 report detected rate code
// [RULE12] Status 5 carrier acquired, cleared when disabled
// [RULE13] Status 4 delimiter found, cleared when disabled
// [RULE14] Status 3 signal valid on code match
// [RULE15] Status 2 header CRC valid, cleared disabled
// [RULE16] Status 1 antenna at last valid CRC
// [RULE17] Receive status register is read only
// [RULE18] Capture received service byte for reading
// [RULE19] Capture received length bytes for reading
// [RULE20] Rate 00 sends external 1 Mbps code
// [RULE21] Status bit 0 reads zero
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module hfc_header_field
	import hfc_pkg::*;
(
	// Clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Controller and receive parser
	input wire logic i_receive_path_enable,
	input wire hfc_rx_evt_s i_rx_evt,
	// Transmit framer
	input wire logic [7:0] i_code_diff_binary,
	output hfc_tx_hdr_s o_tx_hdr
);

	// Configuration registers
	logic [7:0] code_quad_diff_q;
	logic [7:0] code_walsh_bin_q;
	logic [7:0] code_walsh_quad_q;
	logic [7:0] tx_rate_q;
	logic [7:0] tx_service_q;
	logic [7:0] tx_len_high_q;
	logic [7:0] tx_len_low_q;
	// Receive status registers
	logic [1:0] rx_rate_q;
	logic rx_acq_q;
	logic rx_sfd_q;
	logic rx_sig_ok_q;
	logic rx_crc_ok_q;
	logic rx_ant_a_q;
	logic [7:0] rx_service_q;
	logic [7:0] rx_len_high_q;
	logic [7:0] rx_len_low_q;
	// Bus and match signals
	logic wr_en;
	logic access_wait;
	logic [31:0] rd_d;
	logic map_hit_d;
	logic ro_hit_d;
	logic [7:0] sel_code_d;
	logic sig_match_d;
	logic [1:0] sig_rate_d;
	logic [7:0] rx_status;

	// Write is committed only at the edge where the master sees pready high
	assign wr_en = i_psel && i_penable && i_pwrite && o_pready && !o_pslverr;
	assign access_wait = i_psel && i_penable && !o_pready;

	// Received signal byte against the external code and the three stored codes
	always_comb
	begin
		sig_match_d = 1'b1;
		sig_rate_d = HFC_RATE_1M;
		if (i_rx_evt.sig_byte == i_code_diff_binary) // [RULE4]
			sig_rate_d = HFC_RATE_1M;
		else if (i_rx_evt.sig_byte == code_quad_diff_q)
			sig_rate_d = HFC_RATE_2M;
		else if (i_rx_evt.sig_byte == code_walsh_bin_q)
			sig_rate_d = HFC_RATE_5M5;
		else if (i_rx_evt.sig_byte == code_walsh_quad_q)
			sig_rate_d = HFC_RATE_11M;
		else
			sig_match_d = 1'b0;
	end

	// Transmit code selection from the two low rate bits only
	always_comb
	begin
		case (tx_rate_q[HFC_RATE_MSB:0]) // [RULE5] [RULE7]
			HFC_RATE_1M: sel_code_d = i_code_diff_binary; // [RULE20]
			HFC_RATE_2M: sel_code_d = code_quad_diff_q; // [RULE1]
			HFC_RATE_5M5: sel_code_d = code_walsh_bin_q; // [RULE2]
			HFC_RATE_11M: sel_code_d = code_walsh_quad_q; // [RULE3]
			default: sel_code_d = i_code_diff_binary;
		endcase
	end

	// Receive status byte as software sees it
	always_comb
	begin
		rx_status = HFC_RST_ZERO;
		rx_status[HFC_ST_RATE_LSB +: 2] = rx_rate_q; // [RULE11]
		rx_status[HFC_ST_ACQ] = rx_acq_q;
		rx_status[HFC_ST_SFD] = rx_sfd_q;
		rx_status[HFC_ST_SIG_OK] = rx_sig_ok_q;
		rx_status[HFC_ST_CRC_OK] = rx_crc_ok_q;
		rx_status[HFC_ST_ANT_A] = rx_ant_a_q;
		rx_status[HFC_ST_ZERO] = 1'b0; // [RULE21]
	end

	// Read mux and address decode; upper data bits read as zero
	always_comb
	begin
		rd_d = '0;
		map_hit_d = 1'b1;
		ro_hit_d = 1'b0;
		case (i_paddr)
			HFC_OFS_CODE_QUAD_DIFF: rd_d[7:0] = code_quad_diff_q;
			HFC_OFS_CODE_WALSH_BIN: rd_d[7:0] = code_walsh_bin_q;
			HFC_OFS_CODE_WALSH_QUAD: rd_d[7:0] = code_walsh_quad_q;
			HFC_OFS_TX_RATE: rd_d[7:0] = tx_rate_q;
			HFC_OFS_TX_SERVICE: rd_d[7:0] = tx_service_q;
			HFC_OFS_TX_LEN_HIGH: rd_d[7:0] = tx_len_high_q;
			HFC_OFS_TX_LEN_LOW: rd_d[7:0] = tx_len_low_q;
			HFC_OFS_RX_STATUS:
			begin
				rd_d[7:0] = rx_status;
				ro_hit_d = 1'b1;
			end
			HFC_OFS_RX_SERVICE:
			begin
				rd_d[7:0] = rx_service_q;
				ro_hit_d = 1'b1;
			end
			HFC_OFS_RX_LEN_HIGH:
			begin
				rd_d[7:0] = rx_len_high_q;
				ro_hit_d = 1'b1;
			end
			HFC_OFS_RX_LEN_LOW:
			begin
				rd_d[7:0] = rx_len_low_q;
				ro_hit_d = 1'b1;
			end
			default: map_hit_d = 1'b0;
		endcase
	end

	// APB answer: one wait state so that data and ready come from flops
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= '0;
		end
		else if (i_ce)
		begin
			o_pready <= access_wait;
			// Writes to read-only status are refused, so they cannot corrupt it
			o_pslverr <= access_wait && (!map_hit_d || (i_pwrite && ro_hit_d)); // [RULE17]
			o_prdata <= (access_wait && !i_pwrite) ? rd_d : '0;
		end
	end

	// Configuration writes; the low byte lane carries the register
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			code_quad_diff_q <= HFC_RST_CODE_QUAD_DIFF;
			code_walsh_bin_q <= HFC_RST_CODE_WALSH_BIN;
			code_walsh_quad_q <= HFC_RST_CODE_WALSH_QUAD;
			tx_rate_q <= HFC_RST_ZERO;
			tx_service_q <= HFC_RST_ZERO;
			tx_len_high_q <= HFC_RST_ZERO;
			tx_len_low_q <= HFC_RST_ZERO;
		end
		else if (i_ce && wr_en)
		begin
			case (i_paddr)
				HFC_OFS_CODE_QUAD_DIFF: code_quad_diff_q <= i_pwdata[7:0]; // [RULE1]
				HFC_OFS_CODE_WALSH_BIN: code_walsh_bin_q <= i_pwdata[7:0]; // [RULE2]
				HFC_OFS_CODE_WALSH_QUAD: code_walsh_quad_q <= i_pwdata[7:0]; // [RULE3]
				HFC_OFS_TX_RATE: tx_rate_q <= i_pwdata[7:0]; // [RULE7]
				HFC_OFS_TX_SERVICE: tx_service_q <= i_pwdata[7:0]; // [RULE8]
				HFC_OFS_TX_LEN_HIGH: tx_len_high_q <= i_pwdata[7:0]; // [RULE10]
				HFC_OFS_TX_LEN_LOW: tx_len_low_q <= i_pwdata[7:0]; // [RULE10]
				default: ;
			endcase
		end
	end

	// Header fields to the framer, registered so the outputs come from flops.
	// The controller must settle the rate well ahead of the signal field.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			o_tx_hdr <= '0;
		else if (i_ce)
		begin
			o_tx_hdr.signal <= sel_code_d; // [RULE5]
			o_tx_hdr.service <= tx_service_q; // [RULE8]
			o_tx_hdr.length <= {tx_len_high_q, tx_len_low_q}; // [RULE10]
		end
	end

	// Search flags: held clear while the receive path is off, clear wins then
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			rx_acq_q <= 1'b0;
			rx_sfd_q <= 1'b0;
		end
		else if (i_ce)
		begin
			if (!i_receive_path_enable)
			begin
				rx_acq_q <= 1'b0; // [RULE12]
				rx_sfd_q <= 1'b0; // [RULE13]
			end
			else
			begin
				if (i_rx_evt.carrier_acq)
					rx_acq_q <= 1'b1; // [RULE12]
				if (i_rx_evt.sfd_found)
					rx_sfd_q <= 1'b1; // [RULE13]
			end
		end
	end

	// Signal field result; the detected rate keeps its last value when off
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			rx_rate_q <= HFC_RATE_1M;
			rx_sig_ok_q <= 1'b0;
		end
		else if (i_ce)
		begin
			if (!i_receive_path_enable)
				rx_sig_ok_q <= 1'b0; // [RULE14]
			else if (i_rx_evt.sig_stb)
			begin
				rx_sig_ok_q <= sig_match_d; // [RULE14]
				if (sig_match_d)
					rx_rate_q <= sig_rate_d; // [RULE11]
			end
		end
	end

	// Header CRC and antenna; antenna only follows a valid CRC
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			rx_crc_ok_q <= 1'b0;
			rx_ant_a_q <= 1'b0;
		end
		else if (i_ce)
		begin
			if (!i_receive_path_enable)
				rx_crc_ok_q <= 1'b0; // [RULE15]
			else if (i_rx_evt.crc_stb)
			begin
				rx_crc_ok_q <= i_rx_evt.crc_ok; // [RULE15]
				if (i_rx_evt.crc_ok)
					rx_ant_a_q <= i_rx_evt.antenna_a; // [RULE16]
			end
		end
	end

	// Received service and length bytes, captured while receiving
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			rx_service_q <= HFC_RST_ZERO;
			rx_len_high_q <= HFC_RST_ZERO;
			rx_len_low_q <= HFC_RST_ZERO;
		end
		else if (i_ce && i_receive_path_enable)
		begin
			if (i_rx_evt.svc_stb)
				rx_service_q <= i_rx_evt.svc_byte; // [RULE18]
			if (i_rx_evt.len_hi_stb)
				rx_len_high_q <= i_rx_evt.len_byte; // [RULE19]
			if (i_rx_evt.len_lo_stb)
				rx_len_low_q <= i_rx_evt.len_byte; // [RULE19]
		end
	end

	// Checks on the status, transmit and APB paths
	enable_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE12]
		(i_ce && !i_receive_path_enable) |=> (rx_status[HFC_ST_ACQ:HFC_ST_CRC_OK] == 4'h0))
		else $error("status flags not cleared while receive disabled");

	acq_set_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE12]
		(i_ce && i_receive_path_enable && i_rx_evt.carrier_acq) |=> rx_acq_q)
		else $error("carrier acquired flag not set");

	sfd_set_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE13]
		(i_ce && i_receive_path_enable && i_rx_evt.sfd_found) |=> rx_sfd_q)
		else $error("delimiter flag not set");

	sig_match_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE14]
		(i_ce && i_receive_path_enable && i_rx_evt.sig_stb
		&& i_rx_evt.sig_byte == code_walsh_quad_q && i_rx_evt.sig_byte != i_code_diff_binary
		&& i_rx_evt.sig_byte != code_quad_diff_q && i_rx_evt.sig_byte != code_walsh_bin_q)
		|=> (rx_sig_ok_q && rx_rate_q == HFC_RATE_11M))
		else $error("stored code match not reported");

	crc_ant_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE16]
		(i_ce && i_receive_path_enable && i_rx_evt.crc_stb && i_rx_evt.crc_ok)
		|=> (rx_crc_ok_q && rx_ant_a_q == $past(i_rx_evt.antenna_a)))
		else $error("crc valid or antenna not recorded");

	ant_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE16]
		!(i_ce && i_rx_evt.crc_stb && i_rx_evt.crc_ok && i_receive_path_enable)
		|=> $stable(rx_ant_a_q))
		else $error("antenna changed without valid crc");

	tx_sel_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE5]
		(i_ce && tx_rate_q[HFC_RATE_MSB:0] == HFC_RATE_5M5)
		|=> (o_tx_hdr.signal == $past(code_walsh_bin_q)))
		else $error("wrong signalling code for rate setting");

	tx_len_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE10]
		i_ce |=> (o_tx_hdr.length == {$past(tx_len_high_q), $past(tx_len_low_q)}))
		else $error("transmit length not formed from both bytes");

	ro_status_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE17]
		(i_ce && access_wait && i_pwrite && i_paddr == HFC_OFS_RX_STATUS) |=> (o_pready && o_pslverr))
		else $error("write to status not refused");

	apb_ready_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(i_ce && o_pready) |=> !o_pready)
		else $error("pready held beyond one cycle");

	status_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE21]
		(o_pready && !i_pwrite && i_paddr == HFC_OFS_RX_STATUS) |-> (o_prdata[0] == 1'b0))
		else $error("status bit 0 not zero");

	full_hdr_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		rx_acq_q && rx_sfd_q && rx_sig_ok_q && rx_crc_ok_q);
	bad_sig_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		i_receive_path_enable && i_rx_evt.sig_stb && !sig_match_d);
	rate_11m_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		tx_rate_q[HFC_RATE_MSB:0] == HFC_RATE_11M);
	slverr_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		o_pready && o_pslverr);

endmodule : hfc_header_field

`default_nettype wire

// [hfc_pkg.sv]
// Package for the header-field configuration and receive-status block.
// Assumes one 200 MHz clock domain and an APB register bus with 32-bit data.
package hfc_pkg;

	// Register byte offsets
	localparam logic [7:0] HFC_OFS_CODE_QUAD_DIFF = 8'h44;
	localparam logic [7:0] HFC_OFS_CODE_WALSH_BIN = 8'h48;
	localparam logic [7:0] HFC_OFS_CODE_WALSH_QUAD = 8'h4C;
	localparam logic [7:0] HFC_OFS_TX_RATE = 8'h50;
	localparam logic [7:0] HFC_OFS_TX_SERVICE = 8'h54;
	localparam logic [7:0] HFC_OFS_TX_LEN_HIGH = 8'h58;
	localparam logic [7:0] HFC_OFS_TX_LEN_LOW = 8'h5C;
	localparam logic [7:0] HFC_OFS_RX_STATUS = 8'h60;
	localparam logic [7:0] HFC_OFS_RX_SERVICE = 8'h64;
	localparam logic [7:0] HFC_OFS_RX_LEN_HIGH = 8'h68;
	localparam logic [7:0] HFC_OFS_RX_LEN_LOW = 8'h6C;

	// Reset values: nominal protocol codes, everything else zero
	localparam logic [7:0] HFC_RST_CODE_QUAD_DIFF = 8'h14;
	localparam logic [7:0] HFC_RST_CODE_WALSH_BIN = 8'h37;
	localparam logic [7:0] HFC_RST_CODE_WALSH_QUAD = 8'h6E;
	localparam logic [7:0] HFC_RST_ZERO = 8'h00;

	// Rate encoding shared by transmit setting and receive status
	localparam logic [1:0] HFC_RATE_1M = 2'h0;
	localparam logic [1:0] HFC_RATE_2M = 2'h1;
	localparam logic [1:0] HFC_RATE_5M5 = 2'h2;
	localparam logic [1:0] HFC_RATE_11M = 2'h3;

	// Receive status field positions
	localparam int HFC_ST_RATE_LSB = 6;
	localparam int HFC_ST_ACQ = 5;
	localparam int HFC_ST_SFD = 4;
	localparam int HFC_ST_SIG_OK = 3;
	localparam int HFC_ST_CRC_OK = 2;
	localparam int HFC_ST_ANT_A = 1;
	localparam int HFC_ST_ZERO = 0;
	localparam int HFC_RATE_MSB = 1;

	// Rate setting must precede its use in the frame by this much
	localparam int HFC_TX_RATE_SETUP_NS = 2000;
	localparam int HFC_CLK_PERIOD_NS = 5;
	localparam int HFC_TX_RATE_SETUP_CYC = (HFC_TX_RATE_SETUP_NS + HFC_CLK_PERIOD_NS - 1)
		/ HFC_CLK_PERIOD_NS;

	// Events from the receive header parser, same clock domain
	typedef struct packed {
		logic carrier_acq;
		logic sfd_found;
		logic sig_stb;
		logic [7:0] sig_byte;
		logic svc_stb;
		logic [7:0] svc_byte;
		logic len_hi_stb;
		logic len_lo_stb;
		logic [7:0] len_byte;
		logic crc_stb;
		logic crc_ok;
		logic antenna_a;
	} hfc_rx_evt_s;

	// Header fields handed to the transmit framer
	typedef struct packed {
		logic [7:0] signal;
		logic [7:0] service;
		logic [15:0] length;
	} hfc_tx_hdr_s;

endpackage : hfc_pkg

// [hfc_mac_model.sv]
// Model of the controller and receive parser that feed the header block.
// Assumes the block's clock; the bench calls the tasks hierarchically.
`timescale 1ns/1ps
`default_nettype none
module hfc_mac_model
	import hfc_pkg::*;
(
	// Clock
	input wire logic i_clk,
	// Receive side
	output logic o_rx_en,
	output hfc_rx_evt_s o_evt
);
	// Quiet start
	initial
	begin
		o_rx_en = 1'b0;
		o_evt = '0;
	end
	// Enable is a level, changed just after an edge
	task automatic set_en(input logic en);
		@(posedge i_clk);
		o_rx_en <= en;
	endtask : set_en
	// One-cycle event; data lines then show the inverse so stale bytes never look valid
	task automatic pulse(input hfc_rx_evt_s e);
		hfc_rx_evt_s idle;
		idle = ~e;
		idle.carrier_acq = 1'b0;
		idle.sfd_found = 1'b0;
		idle.sig_stb = 1'b0;
		idle.svc_stb = 1'b0;
		idle.len_hi_stb = 1'b0;
		idle.len_lo_stb = 1'b0;
		idle.crc_stb = 1'b0;
		@(posedge i_clk);
		o_evt <= e;
		@(posedge i_clk);
		o_evt <= idle;
	endtask : pulse
endmodule : hfc_mac_model
`default_nettype wire

// [test_header_field_config_status.sv]
// Self-checking bench: APB results queued as notes, rx events, tx header.
// Assumes hfc_mac_model on the receive side; clock enable dropped once to check freezing.
`timescale 1ns/1ps
`default_nettype none
module test_header_field_config_status
	import hfc_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] code_diff = 8'h00;
	logic ce = 1'b1;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rx_en;
	hfc_rx_evt_s evt;
	hfc_tx_hdr_s hdr;
	int n_errors = 0;
	int compares = 0;
	logic [31:0] seed = 32'h30;
	logic [32:0] expq[$];
	logic [7:0] base, svc, lh, ll;
	logic [1:0] s_rate = 2'h0;
	logic s_acq = 1'b0, s_sfd = 1'b0, s_sig = 1'b0, s_crc = 1'b0, s_ant = 1'b0;

	hfc_header_field dut (.i_sys_clk(clk), .i_rst(rst), .i_ce(ce), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_receive_path_enable(rx_en), .i_rx_evt(evt), .i_code_diff_binary(code_diff),
		.o_tx_hdr(hdr));
	hfc_mac_model mac (.i_clk(clk), .o_rx_en(rx_en), .o_evt(evt));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [31:0] stat();
		return {24'h0, s_rate, s_acq, s_sfd, s_sig, s_crc, s_ant, 1'b0};
	endfunction : stat

	task automatic err(input string m);
		n_errors++;
		$display("MISMATCH at %0t: %s", $time, m);
	endtask : err

	task automatic cmp_apb(input logic [32:0] e, input logic [32:0] g);
		compares++;
		if (g !== e)
			err($sformatf("apb got %h want %h", g, e));
	endtask : cmp_apb

	task automatic cmp_hdr(input hfc_tx_hdr_s e);
		compares++;
		if (hdr !== e)
			err($sformatf("tx header got %h want %h", hdr, e));
	endtask : cmp_hdr

	// Master holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] ed, input logic ee);
		int n;
		expq.push_back({ee, ed});
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge clk);
		end
		if (n == 50)
			err("no pready");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Upper data bits are random: the slave must ignore them
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [31:0] r;
		r = xs();
		apb(1'b1, a, {r[31:8], v}, 32'h0, 1'b0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] v);
		apb(1'b0, a, 32'h0, {24'h0, v}, 1'b0);
	endtask : rd

	task automatic ev(input int k, input logic [7:0] b);
		hfc_rx_evt_s e;
		e = '0;
		e.sig_byte = b;
		e.svc_byte = b;
		e.len_byte = b;
		e.crc_ok = b[0];
		e.antenna_a = b[1];
		case (k)
			0: e.carrier_acq = 1'b1;
			1: e.sfd_found = 1'b1;
			2: e.sig_stb = 1'b1;
			3: e.svc_stb = 1'b1;
			4: e.len_hi_stb = 1'b1;
			5: e.len_lo_stb = 1'b1;
			default: e.crc_stb = 1'b1;
		endcase
		mac.pulse(e);
	endtask : ev

	task automatic finish_test();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	// Monitor: every answer takes the oldest note
	always @(posedge clk)
	begin
		if (pready === 1'b1)
		begin
			if (expq.size() == 0)
				err("unexpected pready");
			else
				cmp_apb(expq.pop_front(), {pslverr, prdata});
		end
	end

	// Watchdog, well beyond the fewer than two thousand cycles the tests need
	initial
	begin
		#100000;
		err("timeout");
		finish_test();
	end

	initial
	begin
		base = 8'(xs());
		code_diff = base;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 11; i++)
			rd(8'h44 + 8'(4 * i), i == 0 ? HFC_RST_CODE_QUAD_DIFF : i == 1 ?
				HFC_RST_CODE_WALSH_BIN : i == 2 ? HFC_RST_CODE_WALSH_QUAD : HFC_RST_ZERO);
		cmp_hdr({base, 8'h00, 16'h0000});
		$display("test reset values done");
		apb(1'b0, 8'h70, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 8'h00, 32'hFF, 32'h0, 1'b1);
		apb(1'b1, HFC_OFS_RX_STATUS, 32'hFF, 32'h0, 1'b1);
		rd(HFC_OFS_RX_STATUS, 8'h00);
		$display("test refusals done");
		for (int j = 1; j < 4; j++)
		begin
			wr(8'h40 + 8'(4 * j), base ^ 8'(j));
			rd(8'h40 + 8'(4 * j), base ^ 8'(j));
		end
		svc = 8'(xs());
		lh = 8'(xs());
		ll = 8'(xs());
		wr(HFC_OFS_TX_SERVICE, svc);
		wr(HFC_OFS_TX_LEN_HIGH, lh);
		wr(HFC_OFS_TX_LEN_LOW, ll);
		for (int r = 0; r < 4; r++)
		begin
			logic [7:0] v;
			v = {6'(xs() >> 26), 2'(r)};
			wr(HFC_OFS_TX_RATE, v);
			rd(HFC_OFS_TX_RATE, v);
			repeat (HFC_TX_RATE_SETUP_CYC) @(posedge clk);
			cmp_hdr({base ^ 8'(r), svc, lh, ll});
		end
		wr(HFC_OFS_TX_SERVICE, 8'h00);
		repeat (3) @(posedge clk);
		cmp_hdr({base ^ 8'h03, 8'h00, lh, ll});
		$display("test tx header done");
		ev(0, 8'h00);
		rd(HFC_OFS_RX_STATUS, stat());
		mac.set_en(1'b1);
		ev(0, 8'h00);
		s_acq = 1'b1;
		rd(HFC_OFS_RX_STATUS, stat());
		ev(1, 8'h00);
		s_sfd = 1'b1;
		rd(HFC_OFS_RX_STATUS, stat());
		for (int r = 0; r < 4; r++)
		begin
			ev(2, base ^ 8'(r));
			s_rate = 2'(r);
			s_sig = 1'b1;
			rd(HFC_OFS_RX_STATUS, stat());
		end
		// A mismatching byte while the clock enable is low must leave status frozen
		@(posedge clk);
		ce <= 1'b0;
		ev(2, base ^ 8'h80);
		ce <= 1'b1;
		rd(HFC_OFS_RX_STATUS, stat());
		ev(2, base ^ 8'h80);
		s_sig = 1'b0;
		rd(HFC_OFS_RX_STATUS, stat());
		ev(6, 8'h03);
		s_crc = 1'b1;
		s_ant = 1'b1;
		rd(HFC_OFS_RX_STATUS, stat());
		ev(6, 8'h00);
		s_crc = 1'b0;
		rd(HFC_OFS_RX_STATUS, stat());
		ev(3, lh);
		ev(4, ll);
		ev(5, svc);
		rd(HFC_OFS_RX_SERVICE, lh);
		rd(HFC_OFS_RX_LEN_HIGH, ll);
		rd(HFC_OFS_RX_LEN_LOW, svc);
		// Valid CRC on antenna B replaces the earlier antenna A record
		ev(6, 8'h01);
		s_crc = 1'b1;
		s_ant = 1'b0;
		rd(HFC_OFS_RX_STATUS, stat());
		mac.set_en(1'b0);
		@(posedge clk);
		{s_acq, s_sfd, s_sig, s_crc} = 4'h0;
		rd(HFC_OFS_RX_STATUS, stat());
		$display("test rx status done");
		repeat (4) @(posedge clk);
		finish_test();
	end
endmodule : test_header_field_config_status
`default_nettype wire
